// [rtl/scr_sysconfig.sv]
// System configuration register with its serial frame access and read-back path.
//
// Notes on behaviour
// - Frames with address bits 15:14 equal to 10 reach this register pair.
// - Bit 13 set returns general purpose feedback 0, clear returns configuration feedback.
// - Bit 12 set only reads; clear reads and also stores the configuration bits.
// - Bit 9 chooses the widened or normal ground offset threshold.
// - Bit 8 chooses long (1) or short (0) reset lengthening.
// - Bits 7:6 set auxiliary supply: long cyclic, short cyclic, on, off.
// - Bit 4 decides if a standby supply current rise resets or wakes the watchdog.
// - Bit 3 enables the wake input; when clear, wake status never changes.
// - Bit 2 chooses cyclic (1) or continuous (0) wake sampling.
// - Bit 1 enables the inhibit fallback pin driver, else the pin floats.
// - Bit 0 sets the inhibit fallback pin level while the driver is on.
// - Entering restart or fail-safe forces the reset length bit to long.
// - External reset pulses are lengthened to the programmed reset length.
// - A frame not of exactly sixteen clocks is discarded without any change.
`timescale 1ns/1ns
`default_nettype none
module scr_sysconfig #(
    parameter int SHORT_CYC = scr_pkg::RST_SHORT_CYC,
    parameter int LONG_CYC = scr_pkg::RST_LONG_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire scr_pkg::scr_frame_s frame,
    output logic spi_sdo,
    output logic spi_count_fault,
    input wire logic [11:0] gp_feedback0,
    input wire logic enter_restart,
    input wire logic enter_failsafe,
    input wire logic standby,
    input wire logic watchdog_off,
    input wire logic mcu_current_rise,
    output logic mcu_current_reset,
    output logic watchdog_reenable,
    input wire logic wake_pin,
    input wire logic wake_sample_tick,
    output logic wake_edge_status,
    output logic wake_level_status,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    output logic ground_offset_threshold_sel,
    output logic reset_stretch_select,
    output scr_pkg::scr_aux_e aux_supply_control,
    output scr_pkg::scr_aux_s aux_supply,
    output logic inhibit_fallback_pin_out,
    output logic inhibit_fallback_pin_oe
);

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------

    // Answer word: the four header bits read as zero, a frame to another
    // register gets an all-zero answer from this block.
    function automatic logic [15:0] read_word(input logic hit, input logic sel,
                                              input logic [11:0] cfg, input logic [11:0] gp);
        logic [11:0] data;
        data = sel ? gp : cfg;
        read_word = hit ? {4'h0, data} : 16'h0000;
    endfunction

    // Auxiliary supply decode into the controls the supply hardware needs.
    // Off clears all three controls.
    function automatic scr_pkg::scr_aux_s aux_decode(input scr_pkg::scr_aux_e mode);
        scr_pkg::scr_aux_s a;
        a.on = (mode != scr_pkg::SCR_AUX_OFF);
        a.cyclic = (mode == scr_pkg::SCR_AUX_CYC_SHORT) || (mode == scr_pkg::SCR_AUX_CYC_LONG);
        a.long_period = (mode == scr_pkg::SCR_AUX_CYC_LONG);
        aux_decode = a;
    endfunction

    // -------------------------------------------------------------------------
    // Frame decoding
    // -------------------------------------------------------------------------
    scr_pkg::scr_state_s s_q;
    scr_pkg::scr_state_s s_d;

    // Events decoded from the pins.
    logic sck_rise;
    logic csn_fall;
    logic frame_end;

    // Write decision and answer word.
    logic frame_ok;
    logic do_write;
    logic force_long;
    logic [15:0] tx_word;

    // Pins are synchronous, so a one-cycle delayed copy finds the edges.
    assign sck_rise = !frame.csn && frame.sck && !s_q.sck_q;
    assign csn_fall = !frame.csn && s_q.csn_q;
    assign frame_end = frame.csn && !s_q.csn_q;
    assign frame_ok = (s_q.cnt == 5'(scr_pkg::FRAME_BITS));
    assign do_write = frame_end && frame_ok && (s_q.rx[scr_pkg::ADDR_HI:scr_pkg::ADDR_LO] == scr_pkg::ADDR_SYSCFG)
                      && !s_q.rx[scr_pkg::NOWR_BIT];

    // Restart and fail-safe entry both force the long reset length.
    assign force_long = enter_restart || enter_failsafe;
    assign tx_word = read_word(s_q.hit, s_q.sel, s_q.cfg, gp_feedback0);

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------

    // Data is shifted in MSB first on the rising clock; the answer bit for the
    // next position is set up right after, so the master sees it half a
    // clock period before it samples. Address and select are known after the
    // second and third bit; the select is ready one bit before the first data bit goes out.
    always_comb begin
        s_d = s_q;
        s_d.sck_q = frame.sck;
        s_d.csn_q = frame.csn;
        s_d.cur_rst = 1'b0;
        s_d.wd_re = 1'b0;
        s_d.fault = 1'b0;

        // A new frame starts from a clean slate.
        if (csn_fall) begin
            s_d.cnt = 5'h00;
            s_d.rx = 16'h0000;
            s_d.hit = 1'b0;
            s_d.sel = 1'b0;
            s_d.sdo = 1'b0;
        end else if (sck_rise) begin
            s_d.rx = {s_q.rx[14:0], frame.sdi};
            // Saturating keeps a long frame from wrapping back to sixteen.
            if (s_q.cnt != 5'h1f) begin
                s_d.cnt = s_q.cnt + 5'h01;
            end
            // The address is complete after two bits.
            if (s_d.cnt == 5'h02) begin
                s_d.hit = (s_d.rx[1:0] == scr_pkg::ADDR_SYSCFG);
            end
            // The select bit is the third one in.
            if (s_d.cnt == 5'h03) begin
                s_d.sel = frame.sdi;
            end
            // Clocks past the sixteenth shift out zeros.
            if (s_d.cnt < 5'h10) begin
                s_d.sdo = tx_word[4'(5'h0f - s_d.cnt)];
            end else begin
                s_d.sdo = 1'b0;
            end
        end

        // A bad clock count only raises the fault pulse; nothing is stored.
        if (frame_end) begin
            s_d.sdo = 1'b0;
            if (!frame_ok) begin
                s_d.fault = 1'b1;
            end
            if (do_write) begin
                s_d.cfg = s_q.rx[11:0] & scr_pkg::CFG_WRITABLE;
            end
        end
        // Mode entry wins over a write in the same cycle, so the safe length holds.
        if (force_long) begin
            s_d.cfg[scr_pkg::RST_LEN_BIT] = 1'b1;
        end

        // Current rise response, only in standby with the watchdog off.
        if (mcu_current_rise && standby && watchdog_off) begin
            if (s_q.cfg[scr_pkg::CMW_BIT]) begin
                s_d.cur_rst = 1'b1;
            end else begin
                s_d.wd_re = 1'b1;
            end
        end
    end

    // State register; chip select idles high so reset makes no frame end.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.cfg <= scr_pkg::CFG_RESET;
            s_q.csn_q <= 1'b1;
            s_q.sck_q <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------

    // Pulses and serial data out.
    assign spi_sdo = s_q.sdo;
    assign spi_count_fault = s_q.fault;
    assign mcu_current_reset = s_q.cur_rst;
    assign watchdog_reenable = s_q.wd_re;

    // Configuration controls come straight from the stored bits.
    assign ground_offset_threshold_sel = s_q.cfg[scr_pkg::GOT_BIT];
    assign reset_stretch_select = s_q.cfg[scr_pkg::RST_LEN_BIT];
    assign aux_supply_control = scr_pkg::scr_aux_e'(s_q.cfg[scr_pkg::AUX_HI:scr_pkg::AUX_LO]);
    assign aux_supply = aux_decode(aux_supply_control);
    assign inhibit_fallback_pin_oe = s_q.cfg[scr_pkg::LIMP_EN_BIT];
    assign inhibit_fallback_pin_out = s_q.cfg[scr_pkg::LIMP_EN_BIT] & s_q.cfg[scr_pkg::LIMP_LVL_BIT];

    // Reset lengthening follows the stored length bit, including the forced one.
    // A current reset also starts it.
    scr_rst_stretch #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
    ) u_stretch (
        .clk(clk),
        .rstn(rstn),
        .long_sel(s_q.cfg[scr_pkg::RST_LEN_BIT]),
        .start_req(s_q.cur_rst),
        .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe)
    );

    // Wake input gating and sampling style.
    // Cyclic sampling waits for the tick.
    scr_wake_gate u_wake (
        .clk(clk),
        .rstn(rstn),
        .enable(s_q.cfg[scr_pkg::WEN_BIT]),
        .cyclic(s_q.cfg[scr_pkg::WAKE_STYLE_BIT]),
        .sample_tick(wake_sample_tick),
        .wake_pin(wake_pin),
        .wake_edge_status(wake_edge_status),
        .wake_level_status(wake_level_status)
    );

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // A complete sixteen-clock frame to this register pair.
    sequence s_good_end;
        frame_end && frame_ok && (s_q.rx[15:14] == 2'b10) && !force_long;
    endsequence

    // A supply current rise that asks for the reset response.
    sequence s_current_reset;
        mcu_current_rise && standby && watchdog_off && s_q.cfg[4] ##1 mcu_current_reset;
    endsequence

    // A write frame stores its data with the reserved bits cleared.
    cfg_write_a: assert property (s_good_end and !s_q.rx[12] |=> s_q.cfg == ($past(s_q.rx[11:0]) & 12'h3df))
        else $error("Configuration not stored by a write frame.");

    // A read-only frame leaves every stored bit alone.
    read_only_a: assert property (s_good_end and s_q.rx[12] |=> $stable(s_q.cfg))
        else $error("Read-only frame changed the configuration.");

    // A wrong clock count raises the fault and stores nothing.
    bad_count_a: assert property (frame_end && s_q.cnt != 5'd16 && !force_long |=> $stable(s_q.cfg) && spi_count_fault)
        else $error("Frame with wrong clock count was not discarded.");

    // Frames to other registers never touch this one.
    other_addr_a: assert property (frame_end && s_q.rx[15:14] != 2'b10 && !force_long |=> $stable(s_q.cfg))
        else $error("Frame to another address changed the configuration.");

    // Mode entry always leaves the long reset length selected.
    rst_len_force_a: assert property (force_long |=> reset_stretch_select)
        else $error("Reset length not forced long on mode entry.");

    // Answer bit 9 shows which register was selected.
    readback_sel_a: assert property (sck_rise && s_q.cnt == 5'd5 && s_q.hit
                                     |=> spi_sdo == ($past(s_q.sel) ? $past(gp_feedback0[9]) : $past(s_q.cfg[9])))
        else $error("Wrong register returned in the read data.");

    // The reset response also pulls the reset pin low.
    current_reset_a: assert property (s_current_reset |-> !rst_pin_oe || $past(rst_pin_oe) ##1 rst_pin_oe)
        else $error("Supply current rise did not reset.");

    // The watchdog response never pulses the reset output.
    current_watch_a: assert property (mcu_current_rise && standby && watchdog_off && !s_q.cfg[4]
                                      |=> watchdog_reenable && !mcu_current_reset)
        else $error("Supply current rise did not only wake the watchdog.");

    // The fallback pin takes its two bits as soon as a write lands.
    inhibit_pin_a: assert property (s_good_end and !s_q.rx[12] |=> inhibit_fallback_pin_oe == $past(s_q.rx[1])
                                    && inhibit_fallback_pin_out == ($past(s_q.rx[1]) && $past(s_q.rx[0])))
        else $error("Inhibit fallback pin not driven as configured.");

    // Header bits 14 to 12 of the answer always read as zero.
    answer_head_a: assert property (sck_rise && s_q.cnt < 5'd3 |=> !spi_sdo)
        else $error("Answer header bit was not zero.");

    // The data line drops back to zero when the frame ends.
    sdo_idle_a: assert property (frame_end |=> !spi_sdo)
        else $error("Data out not cleared at frame end.");

    // The count fault is a single-cycle pulse.
    fault_pulse_a: assert property (spi_count_fault |=> !spi_count_fault)
        else $error("Count fault pulse lasted more than one cycle.");

endmodule // scr_sysconfig
`default_nettype wire

// [rtl/scr_pkg.sv]
// Constants, types and state records of the system configuration register block.
package scr_pkg;

    // -------------------------------------------------------------------------
    // Frame layout
    // -------------------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 14;
    localparam int SEL_BIT = 13;
    localparam int NOWR_BIT = 12;
    localparam logic [1:0] ADDR_SYSCFG = 2'h2;

    // -------------------------------------------------------------------------
    // Configuration field positions, mask and reset value
    // -------------------------------------------------------------------------
    localparam int GOT_BIT = 9;
    localparam int RST_LEN_BIT = 8;
    localparam int AUX_HI = 7;
    localparam int AUX_LO = 6;
    localparam int CMW_BIT = 4;
    localparam int WEN_BIT = 3;
    localparam int WAKE_STYLE_BIT = 2;
    localparam int LIMP_EN_BIT = 1;
    localparam int LIMP_LVL_BIT = 0;
    localparam logic [11:0] CFG_WRITABLE = 12'h3df;
    localparam logic [11:0] CFG_RESET = 12'h100;

    // -------------------------------------------------------------------------
    // Reset lengthening times
    // -------------------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 25;
    localparam int RST_SHORT_US = 20;
    localparam int RST_LONG_US = 100;
    localparam int RST_SHORT_CYC = RST_SHORT_US * CLK_FREQ_MHZ;
    localparam int RST_LONG_CYC = RST_LONG_US * CLK_FREQ_MHZ;
    localparam int RST_CNT_W = 12;

    // -------------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCR_AUX_OFF = 2'b00,
        SCR_AUX_ON = 2'b01,
        SCR_AUX_CYC_SHORT = 2'b10,
        SCR_AUX_CYC_LONG = 2'b11
    } scr_aux_e;

    typedef struct packed {
        logic csn;
        logic sck;
        logic sdi;
    } scr_frame_s;

    typedef struct packed {
        logic on;
        logic cyclic;
        logic long_period;
    } scr_aux_s;

    typedef struct packed {
        logic [11:0] cfg;
        logic [15:0] rx;
        logic [4:0] cnt;
        logic sck_q;
        logic csn_q;
        logic hit;
        logic sel;
        logic sdo;
        logic cur_rst;
        logic wd_re;
        logic fault;
    } scr_state_s;

    typedef struct packed {
        logic active;
        logic [RST_CNT_W-1:0] cnt;
    } scr_stretch_s;

    typedef struct packed {
        logic level;
        logic edge_evt;
    } scr_wake_s;

endpackage

// [rtl/scr_rst_stretch.sv]
// Reset pin lengthening: holds the open-drain reset pin low for the programmed time.
`timescale 1ns/1ns
`default_nettype none
module scr_rst_stretch #(
    parameter int SHORT_CYC = scr_pkg::RST_SHORT_CYC,
    parameter int LONG_CYC = scr_pkg::RST_LONG_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic long_sel,
    input wire logic start_req,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe
);

    scr_pkg::scr_stretch_s s_q;
    scr_pkg::scr_stretch_s s_d;

    // A low level seen on the pin while idle, or an internal request, starts a
    // full lengthening period. A pin still held low after release retriggers it.
    always_comb begin
        s_d = s_q;
        if (!s_q.active) begin
            if (start_req || !rst_pin_in) begin
                s_d.active = 1'b1;
                s_d.cnt = long_sel ? scr_pkg::RST_CNT_W'(LONG_CYC - 1) : scr_pkg::RST_CNT_W'(SHORT_CYC - 1);
            end
        end else if (s_q.cnt == '0) begin
            s_d.active = 1'b0;
        end else begin
            s_d.cnt = s_q.cnt - scr_pkg::RST_CNT_W'(1);
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // The pin is only ever pulled low, never driven high.
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = s_q.active;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    sequence s_trigger;
        !rst_pin_oe && (start_req || !rst_pin_in);
    endsequence

    stretch_start_a: assert property (s_trigger |=> rst_pin_oe)
        else $error("Reset pin not pulled low after trigger.");
    stretch_hold_a: assert property ($rose(rst_pin_oe) |-> rst_pin_oe [*8])
        else $error("Reset pulse released too early.");

endmodule // scr_rst_stretch
`default_nettype wire

// [rtl/scr_wake_gate.sv]
// Wake input sampling: continuous or cyclic, with a full disable.
`timescale 1ns/1ns
`default_nettype none
module scr_wake_gate (
    input wire logic clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic cyclic,
    input wire logic sample_tick,
    input wire logic wake_pin,
    output logic wake_edge_status,
    output logic wake_level_status
);

    scr_pkg::scr_wake_s s_q;
    scr_pkg::scr_wake_s s_d;
    logic take;

    // Cyclic mode looks at the pin only on the tick; disabled means no update at all.
    assign take = enable && (!cyclic || sample_tick);

    always_comb begin
        s_d = s_q;
        s_d.edge_evt = 1'b0;
        if (take) begin
            s_d.level = wake_pin;
            s_d.edge_evt = s_q.level && !wake_pin;
        end
    end

    // State register; the level starts high so a quiet pin gives no edge.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '{level: 1'b1, edge_evt: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign wake_edge_status = s_q.edge_evt;
    assign wake_level_status = s_q.level;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    wake_disabled_hold_a: assert property (!enable |=> $stable(wake_level_status) && !wake_edge_status)
        else $error("Wake status changed while disabled.");
    wake_cyclic_gate_a: assert property (enable && cyclic && !sample_tick |=> $stable(wake_level_status))
        else $error("Wake sampled between cyclic ticks.");
    wake_cont_follow_a: assert property (enable && !cyclic |=> wake_level_status == $past(wake_pin))
        else $error("Continuous sampling missed the pin.");

endmodule // scr_wake_gate
`default_nettype wire

// [sim/scr_spi_master.sv]
// Serial master model that sends one frame and captures the answer word.
`timescale 1ns/1ns
`default_nettype none
module scr_spi_master (
    input wire logic clk,
    input wire logic spi_sdo,
    output scr_pkg::scr_frame_s frame,
    output logic [15:0] rx_word,
    output logic rx_valid
);
    int hold = 2;

    // The link idles deselected with the clock standing low.
    initial begin
        frame = 3'b100;
        rx_word = 16'h0000;
        rx_valid = 1'b0;
    end

    // Sends nbits MSB first; the clock high phase lasts hold cycles and the low phase hold plus one, so the bench can run fast or slow.
    task automatic xfer(input logic [15:0] word, input int nbits);
        logic [15:0] rx;
        rx = 16'h0000;
        @(negedge clk) frame.csn <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            @(negedge clk);
            frame.sdi <= (i < 16) ? word[15 - i] : 1'b0;
            // The answer bit for this clock stands on the line before it rises.
            if (i < 16) rx[15 - i] = spi_sdo;
            repeat (hold) @(negedge clk);
            frame.sck <= 1'b1;
            repeat (hold) @(negedge clk);
            frame.sck <= 1'b0;
        end
        @(negedge clk);
        frame.csn <= 1'b1;
        // A released data line must not keep looking like the last bit.
        frame.sdi <= ~frame.sdi;
        @(negedge clk);
        rx_word <= rx;
        rx_valid <= (nbits == 16);
        @(negedge clk) rx_valid <= 1'b0;
    endtask
endmodule // scr_spi_master
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the system configuration register block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk, rstn, spi_sdo, spi_count_fault, enter_restart, enter_failsafe, standby, watchdog_off;
    logic mcu_current_rise, mcu_current_reset, watchdog_reenable, wake_pin, wake_sample_tick;
    logic wake_edge_status, wake_level_status, rst_pin_out, rst_pin_oe, rst_ext_n, rx_valid;
    logic ground_offset_threshold_sel, reset_stretch_select, inhibit_fallback_pin_out, inhibit_fallback_pin_oe;
    logic [11:0] gp_feedback0, cfg_m;
    logic [15:0] rx_word;
    wire logic rst_pin_in;
    scr_pkg::scr_frame_s frame;
    scr_pkg::scr_aux_e aux_supply_control;
    scr_pkg::scr_aux_s aux_supply;
    logic [15:0] expq[$];
    int miscompares, num_checks, faults, rst_pulses, wdr_pulses, oe_cnt, edges;

    // The reset pin is open drain with a pull-up: low if the block or the outside pulls it.
    assign rst_pin_in = rst_ext_n & ~rst_pin_oe;

    scr_sysconfig #(.SHORT_CYC(10), .LONG_CYC(20)) uut (.clk, .rstn, .frame, .spi_sdo, .spi_count_fault,
        .gp_feedback0, .enter_restart, .enter_failsafe, .standby, .watchdog_off, .mcu_current_rise,
        .mcu_current_reset, .watchdog_reenable, .wake_pin, .wake_sample_tick, .wake_edge_status,
        .wake_level_status, .rst_pin_in, .rst_pin_out, .rst_pin_oe, .ground_offset_threshold_sel,
        .reset_stretch_select, .aux_supply_control, .aux_supply, .inhibit_fallback_pin_out,
        .inhibit_fallback_pin_oe);

    scr_spi_master m (.clk, .spi_sdo, .frame, .rx_word, .rx_valid);

    // -------------------------------------------------------------------------
    // Checking and reporting
    // -------------------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_cfg();
        chk("threshold", cfg_m[9], ground_offset_threshold_sel);
        chk("rst_len", cfg_m[8], reset_stretch_select);
        chk("aux", cfg_m[7:6], aux_supply_control);
        chk("aux_dec", {|cfg_m[7:6], cfg_m[7], &cfg_m[7:6]},
            {aux_supply.on, aux_supply.cyclic, aux_supply.long_period});
        chk("limp_oe", cfg_m[1], inhibit_fallback_pin_oe);
        chk("limp_out", cfg_m[1] & cfg_m[0], inhibit_fallback_pin_out);
    endtask

    // Notes the answer first, so the expectation uses the contents from before the write.
    task automatic frame_op(input logic [1:0] a, input logic sel, input logic ro, input logic [11:0] d);
        logic [11:0] sent;
        sent = d & 12'h3df;
        expq.push_back((a != 2'h2) ? 16'h0000 : {4'h0, sel ? gp_feedback0 : cfg_m});
        if (a == 2'h2 && !ro) cfg_m = sent;
        m.xfer({a, sel, ro, sent}, 16);
    endtask

    task automatic wr(input logic [11:0] d);
        frame_op(2'h2, 1'b0, 1'b0, d);
    endtask

    // Each answer word is matched against the oldest note.
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            if (expq.size() == 0) begin
                miscompares++;
                $display("unexpected readback: expected none seen %h", rx_word);
            end else begin
                chk("readback", expq.pop_front(), rx_word);
            end
        end
    end

    // Event counters; pulses last one cycle, so each high sample is one event; oe_cnt counts the cycles the reset pin is pulled low.
    always @(posedge clk) begin
        if (spi_count_fault === 1'b1) faults++;
        if (mcu_current_reset === 1'b1) rst_pulses++;
        if (watchdog_reenable === 1'b1) wdr_pulses++;
        if (rst_pin_oe === 1'b1) oe_cnt++;
        if (wake_edge_status === 1'b1) edges++;
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Twenty-four frames of mostly fifty-two cycles each fit well inside this span.
    initial begin
        #(40 * 20000);
        miscompares++;
        results();
    end

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        {rstn, enter_restart, enter_failsafe, standby, watchdog_off, mcu_current_rise} = 6'h00;
        {wake_pin, wake_sample_tick, rst_ext_n} = 3'b101;
        gp_feedback0 = 12'h000;
        void'($urandom(39));
        repeat (16) @(negedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        cfg_m = 12'h100;
        chk_cfg();
        frame_op(2'h2, 1'b0, 1'b1, 12'h000);
        for (int k = 0; k < 4; k++) begin
            m.hold = 1 + k % 3;
            wr(($urandom & 12'h31f) | (k << 6));
            chk_cfg();
        end
        frame_op(2'h2, 1'b0, 1'b1, ~cfg_m);
        chk_cfg();
        gp_feedback0 = 12'($urandom);
        frame_op(2'h2, 1'b1, 1'b0, $urandom);
        frame_op(2'h2, 1'b1, 1'b1, 12'h000);
        for (int a = 0; a < 4; a++) begin
            if (a != 2) frame_op(a[1:0], 1'b0, 1'b0, ~cfg_m);
        end
        chk_cfg();
        m.xfer(16'ha000, 15);
        m.xfer(16'ha000, 17);
        chk("faults", 2, faults);
        chk_cfg();
        // Mode entry overrides a short reset length written before.
        for (int j = 0; j < 2; j++) begin
            wr(12'h000);
            {enter_failsafe, enter_restart} <= 2'h1 << j;
            @(negedge clk);
            {enter_failsafe, enter_restart} <= 2'h0;
            cfg_m[8] = 1'b1;
            repeat (2) @(negedge clk);
            chk_cfg();
            frame_op(2'h2, 1'b0, 1'b1, 12'h000);
        end
        for (int j = 0; j < 2; j++) begin
            wr({3'h0, j[0], 8'h00});
            oe_cnt = 0;
            rst_ext_n <= 1'b0;
            repeat (2) @(negedge clk);
            rst_ext_n <= 1'b1;
            repeat (30) @(negedge clk);
            chk("stretch", j ? 20 : 10, oe_cnt);
            chk("rst_out", 0, rst_pin_out);
        end
        standby <= 1'b1;
        watchdog_off <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            wr({7'h00, ~j[0], 4'h0});
            mcu_current_rise <= 1'b1;
            @(negedge clk);
            mcu_current_rise <= 1'b0;
            repeat (30) @(negedge clk);
        end
        chk("cur_reset", 1, rst_pulses);
        chk("wd_reenable", 1, wdr_pulses);
        wr(12'h000);
        wake_pin <= 1'b0;
        repeat (4) @(negedge clk);
        chk("wake_off", 1, wake_level_status);
        wr(12'h00c);
        chk("wake_no_tick", 1, wake_level_status);
        wake_sample_tick <= 1'b1;
        @(negedge clk);
        wake_sample_tick <= 1'b0;
        @(negedge clk);
        chk("wake_tick", 0, wake_level_status);
        wr(12'h008);
        wake_pin <= 1'b1;
        repeat (2) @(negedge clk);
        chk("wake_cont", 1, wake_level_status);
        chk("wake_edges", 1, edges);
        repeat (4) @(negedge clk);
        chk("pending", 0, expq.size());
        results();
    end
endmodule // tb_top
`default_nettype wire
